// ### dfm_pkg.sv
// shared constants and types for the mode-register bank and its controller
package dfm_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [5:0] ADDR_TRAIN_CTRL = 6'h0d;
   localparam logic [5:0] ADDR_DQ_REF = 6'h0e;
   localparam logic [5:0] ADDR_REFRESH_RATE = 6'h04;
   // ------------------------------------------------------------
   // training control fields
   // ------------------------------------------------------------
   localparam int BIT_CMD_BUS_TRAIN = 0;
   localparam int BIT_RD_PRE_TRAIN = 1;
   localparam int BIT_REF_OUT = 2;
   localparam int BIT_REF_BOOST = 3;
   localparam int BIT_REFRESH_OPT = 4;
   localparam int BIT_DATA_MASK_DIS = 5;
   localparam int BIT_SP_WRITE_SEL = 6;
   localparam int BIT_SP_OPER_SEL = 7;
   localparam logic [7:0] TRAIN_CTRL_RESET = 8'h00;
   // ------------------------------------------------------------
   // dq reference fields
   // ------------------------------------------------------------
   localparam int BIT_DQ_RANGE = 6;
   localparam logic [5:0] DQ_REF_MAX = 6'h32;
   localparam logic [7:0] DQ_REF_RESET = 8'h40;
   localparam logic [7:0] DQ_REF_MASK = 8'h7f;
   // ------------------------------------------------------------
   // refresh-rate codes
   // ------------------------------------------------------------
   localparam logic [2:0] RATE_CODE_A = 3'h1;
   localparam logic [2:0] RATE_CODE_B = 3'h2;
   localparam logic [2:0] RATE_CODE_SUB = 3'h3;
   // ------------------------------------------------------------
   // command encoding
   // ------------------------------------------------------------
   localparam logic [3:0] READ_WAIT_MAX = 4'h4;
   typedef enum logic [1:0] {
      DFM_CMD_NOP = 2'h0,
      DFM_CMD_MRW = 2'h1,
      DFM_CMD_MRR = 2'h2
   } dfm_cmd_e;
   typedef enum logic [3:0] {
      DFM_ST_IDLE = 4'h1,
      DFM_ST_CMD = 4'h2,
      DFM_ST_WAIT = 4'h4,
      DFM_ST_DONE = 4'h8
   } dfm_state_e;
endpackage : dfm_pkg

// ### dfm_link_if.sv
// command/data link between controller and mode-register bank
`timescale 1ns/1ps
interface dfm_link_if
   import dfm_pkg::*;
   (
   input wire logic clk, // command clock
   input wire logic resetn // reset, active low
);
   dfm_cmd_e cmd; // command type
   logic [5:0] ca; // command/address pins
   logic [5:0] addr; // mode-register address
   logic [7:0] wdata; // write operand
   logic cke; // clock enable pin
   logic [7:0] dq_out; // data driven by the device
   logic [7:0] dq_oe_n; // device drive enables, low drives
   logic rvalid; // read data valid
   logic [7:0] dq; // resolved bus
   assign dq = dq_out & ~dq_oe_n;
   modport device (input cmd, input ca, input addr, input wdata, input cke,
      output dq_out, output dq_oe_n, output rvalid);
   modport ctrl (output cmd, output ca, output addr, output wdata, output cke,
      input dq, input rvalid);
endinterface : dfm_link_if

// ### dfm_device.sv
// mode-register bank with dual set points, device end of the link
`timescale 1ns/1ps
// Operation
// - cmd-bus-training bit enters CA training
// - training with cke low mirrors CA
// - controller raises cke before clearing training
// - read-preamble bit enables preamble training
// - reference output uses active set point
// - boost bit selects fast reference mode
// - option low maps codes 1,2 to 3
// - option matters only with capability bit
// - controller follows reported refresh code; dfm_ctrl takes no action on it
// - mask-disable low keeps data masking
// - no masked write when masking disabled
// - write-select picks copy for writes
// - operate-select picks governing copy
// - control register resets to zero
// - reference codes above 0x32 reserved
// - range bit, range 1 default
// - read returns eight bits, reserved zero
// - reference access uses write-select copy
// - only operate copy used, other free
// - range persists until write or reset
// - controller always gives range with setting
module dfm_device
   import dfm_pkg::*;
   (
   input wire logic clk, // command clock
   input wire logic resetn, // reset, active low
   dfm_link_if.device link, // controller link
   input wire logic capability, // identification capability bit
   input wire logic [2:0] rate_raw, // raw refresh-rate code
   output logic cmd_train_active, // command-bus training mode
   output logic rd_pre_train, // read preamble training mode
   output logic ref_out_en, // reference output mode
   output logic ref_boost, // fast reference mode
   output logic mask_enabled, // write data masking honoured
   output logic [5:0] active_dq_ref, // active dq reference code
   output logic active_dq_range, // active dq range
   output logic reserved_code, // last written code reserved
   output logic [2:0] rate_report // reported refresh-rate code
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] train_ctrl;
   logic [7:0] dq_ref [2];
   logic cke_s1, cke_s2, cke_s3;
   logic mirror;
   logic wsel, osel;
   assign wsel = train_ctrl[BIT_SP_WRITE_SEL];
   assign osel = train_ctrl[BIT_SP_OPER_SEL];

   // cke from pin, three-stage sampling
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cke_s1 <= 1'b1;
         cke_s2 <= 1'b1;
         cke_s3 <= 1'b1;
      end else begin
         cke_s1 <= link.cke;
         cke_s2 <= cke_s1;
         cke_s3 <= cke_s2;
      end
   end

   // mirror when training and cke low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mirror <= 1'b0;
      end else if (cke_s2 == cke_s3) begin
         mirror <= train_ctrl[BIT_CMD_BUS_TRAIN] & ~cke_s3;
      end else if (!train_ctrl[BIT_CMD_BUS_TRAIN]) begin
         mirror <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   // zero after reset; write sets training
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         train_ctrl <= TRAIN_CTRL_RESET;
      end else if (!mirror && link.cmd == DFM_CMD_MRW && link.addr == ADDR_TRAIN_CTRL) begin
         train_ctrl <= link.wdata;
      end
   end

   // ------------------------------------------------------------
   // dq reference copies
   // ------------------------------------------------------------
   // writes reach the write-select copy; held until rewritten
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dq_ref[0] <= DQ_REF_RESET;
         dq_ref[1] <= DQ_REF_RESET;
         reserved_code <= 1'b0;
      end else if (!mirror && link.cmd == DFM_CMD_MRW && link.addr == ADDR_DQ_REF) begin
         // reserved top bit stored as zero
         dq_ref[wsel] <= link.wdata & DQ_REF_MASK;
         reserved_code <= link.wdata[5:0] > DQ_REF_MAX;
      end
   end

   // ------------------------------------------------------------
   // read path and mirroring
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link.dq_out <= 8'h00;
         link.dq_oe_n <= 8'hff;
         link.rvalid <= 1'b0;
      end else if (mirror) begin
         // ca pins onto dq, commands ignored
         link.dq_out <= {2'b00, link.ca};
         link.dq_oe_n <= 8'h00;
         link.rvalid <= 1'b0;
      end else if (link.cmd == DFM_CMD_MRR && link.addr == ADDR_DQ_REF) begin
         link.dq_out <= dq_ref[wsel];
         link.dq_oe_n <= 8'h00;
         link.rvalid <= 1'b1;
      end else if (link.cmd == DFM_CMD_MRR && link.addr == ADDR_REFRESH_RATE) begin
         link.dq_out <= {5'h00, rate_report};
         link.dq_oe_n <= 8'h00;
         link.rvalid <= 1'b1;
      end else begin
         link.dq_out <= 8'h00;
         link.dq_oe_n <= 8'hff;
         link.rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // mode outputs
   // ------------------------------------------------------------
   // training mode flag
   assign cmd_train_active = train_ctrl[BIT_CMD_BUS_TRAIN];
   assign rd_pre_train = train_ctrl[BIT_RD_PRE_TRAIN];
   assign ref_out_en = train_ctrl[BIT_REF_OUT];
   assign ref_boost = train_ctrl[BIT_REF_BOOST];
   assign mask_enabled = ~train_ctrl[BIT_DATA_MASK_DIS];
   assign active_dq_ref = dq_ref[osel][5:0];
   assign active_dq_range = dq_ref[osel][BIT_DQ_RANGE];

   always_comb begin
      rate_report = rate_raw;
      if (capability && !train_ctrl[BIT_REFRESH_OPT] &&
          (rate_raw == RATE_CODE_A || rate_raw == RATE_CODE_B)) begin
         rate_report = RATE_CODE_SUB;
      end
   end
endmodule : dfm_device

// ### dfm_ctrl.sv
// controller end issuing mode-register writes and reads
`timescale 1ns/1ps
module dfm_ctrl
   import dfm_pkg::*;
   (
   input wire logic clk, // command clock
   input wire logic resetn, // reset, active low
   dfm_link_if.ctrl link, // device link
   input wire logic req, // start a request, pulse
   input wire logic req_write, // 1 write, 0 read
   input wire logic [5:0] req_addr, // register address
   input wire logic [7:0] req_data, // write operand
   input wire logic cke_req, // requested cke level
   input wire logic [5:0] ca_drive, // ca pattern during training
   output logic busy, // request in progress
   output logic done, // request finished, pulse
   output logic [7:0] rd_data, // read result
   output logic [7:0] dq_sample // sampled bus
);
   dfm_state_e state;
   logic wr_q;
   logic [5:0] addr_q;
   logic [7:0] data_q;
   logic [3:0] wait_cnt;

   assign busy = state != DFM_ST_IDLE;
   assign link.ca = ca_drive;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= DFM_ST_IDLE;
         wr_q <= 1'b0;
         addr_q <= 6'h00;
         data_q <= 8'h00;
         link.cmd <= DFM_CMD_NOP;
         link.addr <= 6'h00;
         link.wdata <= 8'h00;
         done <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         done <= 1'b0;
         link.cmd <= DFM_CMD_NOP;
         case (state)
            DFM_ST_IDLE: begin
               if (req) begin
                  wr_q <= req_write;
                  addr_q <= req_addr;
                  data_q <= req_data;
                  state <= DFM_ST_CMD;
               end
            end
            DFM_ST_CMD: begin
               // hold clear of training until cke high
               if (!(wr_q && addr_q == ADDR_TRAIN_CTRL && !data_q[BIT_CMD_BUS_TRAIN]
                     && !link.cke)) begin
                  link.cmd <= wr_q ? DFM_CMD_MRW : DFM_CMD_MRR;
                  link.addr <= addr_q;
                  link.wdata <= data_q;
                  state <= wr_q ? DFM_ST_DONE : DFM_ST_WAIT;
               end
            end
            DFM_ST_WAIT: begin
               // device answers one cycle after command
               if (link.rvalid) begin
                  rd_data <= link.dq;
                  state <= DFM_ST_DONE;
               end else if (wait_cnt == READ_WAIT_MAX) begin
                  // refused read, give up with zero data
                  rd_data <= 8'h00;
                  state <= DFM_ST_DONE;
               end
            end
            DFM_ST_DONE: begin
               done <= 1'b1;
               state <= DFM_ST_IDLE;
            end
            default: state <= DFM_ST_IDLE;
         endcase
      end
   end

   // bound on an unanswered read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_cnt <= 4'h0;
      end else if (state == DFM_ST_WAIT) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         wait_cnt <= 4'h0;
      end
   end

   // cke steered by the user, registered one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link.cke <= 1'b1;
         dq_sample <= 8'h00;
      end else begin
         link.cke <= cke_req;
         dq_sample <= link.dq;
      end
   end
endmodule : dfm_ctrl

// ### dfm_link_props.sv
// assertions on the link between controller and mode-register bank
`timescale 1ns/1ps
module dfm_link_props
   import dfm_pkg::*;
   (
   input wire logic clk, // command clock
   input wire logic resetn, // reset, active low
   input wire dfm_cmd_e cmd, // command type
   input wire logic [5:0] ca, // command/address pins
   input wire logic [5:0] addr, // register address
   input wire logic [7:0] wdata, // write operand
   input wire logic cke, // clock enable pin
   input wire logic [7:0] dq_oe_n, // device drive enables
   input wire logic rvalid, // read data valid
   input wire logic [7:0] dq // resolved bus
);
   // ------------------------------------------------------------
   // link properties
   // ------------------------------------------------------------
   logic mirror;
   assign mirror = dq_oe_n == 8'h00 && !rvalid;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_read_answer: assert property (
      cke [*5] ##0 (cmd == DFM_CMD_MRR && addr == ADDR_DQ_REF)
      |=> rvalid && dq_oe_n == 8'h00 && !dq[7]) else $error("reference read not answered");
   a_unmapped_silent: assert property (
      (cmd == DFM_CMD_MRR && addr != ADDR_DQ_REF && addr != ADDR_REFRESH_RATE) |=> !rvalid)
      else $error("answer to unmapped read");
   a_bus_release: assert property (
      cke [*5] ##0 (rvalid && cmd == DFM_CMD_NOP) |=> dq_oe_n == 8'hff && !rvalid)
      else $error("bus not released after read");
   a_answer_cause: assert property (
      rvalid |-> $past(cmd) == DFM_CMD_MRR) else $error("answer without read");
   a_mirror_ca: assert property (
      mirror |-> dq == {2'b00, $past(ca)}) else $error("mirrored bus differs from ca");
   a_mirror_ignores: assert property (
      (mirror && !cke && cmd == DFM_CMD_MRR) |=> !rvalid) else $error("read taken in training");
   a_mirror_ends: assert property (
      cke [*8] |-> !mirror) else $error("mirroring with cke high");
   a_clear_cke_high: assert property (
      (cmd == DFM_CMD_MRW && addr == ADDR_TRAIN_CTRL && !wdata[0]) |-> cke)
      else $error("training cleared with cke low");
   c_mirror: cover property (mirror);
   c_read: cover property (rvalid);
   c_ctrl_write: cover property (cmd == DFM_CMD_MRW && addr == ADDR_TRAIN_CTRL);
endmodule : dfm_link_props

// ### testbench.sv
// self-checking bench joining controller and mode-register bank
`timescale 1ns/1ps
module testbench
   import dfm_pkg::*;
   ;
   logic clk = 1'b0, resetn = 1'b0, capability = 1'b0, req = 1'b0, req_write = 1'b0;
   logic cke_req = 1'b1, cmd_train_active, rd_pre_train, ref_out_en, ref_boost;
   logic mask_enabled, active_dq_range, reserved_code, busy, done;
   logic [2:0] rate_raw = 3'h0, rate_report;
   logic [5:0] req_addr = 6'h00, ca_drive = 6'h00, active_dq_ref;
   logic [7:0] req_data = 8'h00, rd_data, dq_sample;
   int n_mismatch = 0, checked = 0;
   dfm_link_if link (.clk(clk), .resetn(resetn));
   dfm_device dfm_device_inst (.clk(clk), .resetn(resetn), .link(link.device),
      .capability(capability), .rate_raw(rate_raw), .cmd_train_active(cmd_train_active),
      .rd_pre_train(rd_pre_train), .ref_out_en(ref_out_en), .ref_boost(ref_boost),
      .mask_enabled(mask_enabled), .active_dq_ref(active_dq_ref),
      .active_dq_range(active_dq_range), .reserved_code(reserved_code),
      .rate_report(rate_report));
   dfm_ctrl dfm_ctrl_inst (.clk(clk), .resetn(resetn), .link(link.ctrl), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .cke_req(cke_req),
      .ca_drive(ca_drive), .busy(busy), .done(done), .rd_data(rd_data), .dq_sample(dq_sample));
   dfm_link_props dfm_link_props_inst (.clk(clk), .resetn(resetn), .cmd(link.cmd),
      .ca(link.ca), .addr(link.addr), .wdata(link.wdata), .cke(link.cke),
      .dq_oe_n(link.dq_oe_n), .rvalid(link.rvalid), .dq(link.dq));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      req <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_data <= d;
      @(posedge clk);
      req <= 1'b0;
      for (i = 0; i < 50 && done !== 1'b1; i++) begin
         @(posedge clk) #1;
      end
      if (i == 50) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: request never done", $time);
         finish_test();
      end
      @(posedge clk) #1;
   endtask : op
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk({cmd_train_active, rd_pre_train, ref_out_en, ref_boost, mask_enabled, 3'h0},
         8'h08, "control reset");
      chk(8'(busy), 8'h00, "idle after reset");
      chk({active_dq_range, 1'b0, active_dq_ref}, 8'h80, "active reset");
      op(1'b0, ADDR_DQ_REF, 8'h00);
      chk(rd_data, 8'h40, "reference reset read");
   endtask : t_reset
   task automatic t_ctrl_bits();
      for (int b = 1; b < 6; b++) begin
         op(1'b1, ADDR_TRAIN_CTRL, 8'h01 << b);
         chk({4'h0, rd_pre_train, ref_out_en, ref_boost, mask_enabled},
            {4'h0, b == 1, b == 2, b == 3, b != 5}, "mode bit");
      end
   endtask : t_ctrl_bits
   task automatic t_rate();
      logic [2:0] e;
      for (int o = 0; o < 2; o++) begin
         op(1'b1, ADDR_TRAIN_CTRL, 8'(o) << 4);
         for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            capability <= k[3];
            rate_raw <= k[2:0];
            @(posedge clk) #1;
            e = (k[3] && o == 0 && (k[2:0] == 3'h1 || k[2:0] == 3'h2)) ? 3'h3 : k[2:0];
            chk({5'h00, rate_report}, {5'h00, e}, "refresh code");
            op(1'b0, ADDR_REFRESH_RATE, 8'h00);
            chk(rd_data, {5'h00, e}, "refresh code read");
         end
      end
   endtask : t_rate
   task automatic t_set_points();
      op(1'b1, ADDR_TRAIN_CTRL, 8'h40);
      op(1'b1, ADDR_DQ_REF, 8'hb2);
      op(1'b0, ADDR_DQ_REF, 8'h00);
      chk(rd_data, 8'h32, "copy 1 read");
      chk({active_dq_range, 1'b0, active_dq_ref}, 8'h80, "inactive write");
      op(1'b1, ADDR_TRAIN_CTRL, 8'h00);
      op(1'b0, ADDR_DQ_REF, 8'h00);
      chk(rd_data, 8'h40, "copy 0 read");
      op(1'b1, ADDR_TRAIN_CTRL, 8'h80);
      chk({active_dq_range, 1'b0, active_dq_ref}, 8'h32, "operate copy 1");
      op(1'b1, ADDR_DQ_REF, 8'h33);
      chk(8'(reserved_code), 8'h01, "code above top");
      op(1'b1, ADDR_DQ_REF, 8'h72);
      chk(8'(reserved_code), 8'h00, "top code");
      chk({active_dq_range, 1'b0, active_dq_ref}, 8'h32, "operate copy kept");
   endtask : t_set_points
   task automatic t_training();
      op(1'b1, ADDR_TRAIN_CTRL, 8'h01);
      chk(8'(cmd_train_active), 8'h01, "training entry");
      @(posedge clk);
      cke_req <= 1'b0;
      ca_drive <= 6'h2a;
      repeat (8) @(posedge clk);
      #1 chk(link.dq, 8'h2a, "ca mirror");
      chk(dq_sample, 8'h2a, "ca mirror sampled");
      @(posedge clk);
      ca_drive <= 6'h15;
      repeat (2) @(posedge clk);
      #1 chk(link.dq, 8'h15, "ca mirror follows");
      op(1'b0, ADDR_DQ_REF, 8'h00);
      chk(rd_data, 8'h00, "read ignored in training");
      chk(link.dq, 8'h15, "mirror kept over read");
      @(posedge clk);
      cke_req <= 1'b1;
      repeat (8) @(posedge clk);
      op(1'b1, ADDR_TRAIN_CTRL, 8'h00);
      chk(8'(cmd_train_active), 8'h00, "training exit");
      chk(link.dq_oe_n, 8'hff, "bus released");
   endtask : t_training
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk) #1;
      t_reset();
      t_ctrl_bits();
      t_rate();
      t_set_points();
      t_training();
      finish_test();
   end
endmodule : testbench
